/* design/ipt_defs.svh */
`ifndef IPT_DEFS_SVH
`define IPT_DEFS_SVH
// byte offsets on the register bus
`define IPT_OFF_STATUS  8'h00
`define IPT_OFF_CORE    8'h04
`define IPT_OFF_CTL1    8'h08
`define IPT_OFF_CTL2    8'h0C
`define IPT_OFF_FLAG0   8'h10
`define IPT_OFF_EN0     8'h18
`define IPT_OFF_PRIO0   8'h20
`define IPT_OFF_PEND    8'h40
`define IPT_OFF_LAST    8'h74
// field positions
`define IPT_SR_LVL_LO   5
`define IPT_CORE_HIGH   3
`define IPT_C1_NEST     15
`define IPT_C1_OVA      14
`define IPT_C1_OVB      13
`define IPT_C1_COVA     12
`define IPT_C1_COVB     11
`define IPT_C1_ACC_A_OVERFLOW_TRAP_EN    10
`define IPT_C1_ACC_B_OVERFLOW_TRAP_EN    9
`define IPT_C1_CATASTROPHIC_TRAP_EN    8
`define IPT_C1_SFT      7
`define IPT_C1_DIV0     6
`define IPT_C1_DMA      5
`define IPT_C2_ALT      15
`define IPT_VEC_FIRST   7'h08
// external pin to source index
`define IPT_EXT0_SRC    0
`define IPT_EXT1_SRC    20
`define IPT_EXT2_SRC    29
// reset values
`define IPT_PRIO_RST    3'h4
`define IPT_LVL_RST     3'h0
// bus responses
`define IPT_RESP_OKAY   2'h0
`define IPT_RESP_SLVERR 2'h2
`endif

/* design/ipt_pkg.sv */
package ipt_pkg;
  // trap events from the core, one cycle pulses
  typedef struct packed {
    logic ova;
    logic ovb;
    logic cova;
    logic covb;
    logic sft;
    logic div0;
    logic dma;
  } ipt_trap_t;
  // latched pending interrupt
  typedef struct packed {
    logic [6:0] vec;
    logic [3:0] lvl;
  } ipt_pend_t;
endpackage

/* design/ipt_top.sv */
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "ipt_defs.svh"
module ipt_top #(
  parameter int NUM_SRC = 32
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RESET_N,
  input  wire logic               I_AWVALID,
  output logic                    O_AWREADY,
  input  wire logic [7:0]         I_AWADDR,
  input  wire logic               I_WVALID,
  output logic                    O_WREADY,
  input  wire logic [31:0]        I_WDATA,
  input  wire logic [3:0]         I_WSTRB,
  output logic                    O_BVALID,
  input  wire logic               I_BREADY,
  output logic [1:0]              O_BRESP,
  input  wire logic               I_ARVALID,
  output logic                    O_ARREADY,
  input  wire logic [7:0]         I_ARADDR,
  output logic                    O_RVALID,
  input  wire logic               I_RREADY,
  output logic [31:0]             O_RDATA,
  output logic [1:0]              O_RRESP,
  input  wire logic [NUM_SRC-1:0] I_SRC_REQ,
  input  wire logic [2:0]         I_EXT_PIN,
  input  wire ipt_pkg::ipt_trap_t I_TRAP_EVT,
  input  wire logic               I_TRAP_TAKEN,
  input  wire logic               I_CPU_LEVEL_LOAD,
  input  wire logic [3:0]         I_CPU_LEVEL_VAL,
  output logic                    O_IRQ,
  output ipt_pkg::ipt_pend_t      O_PEND,
  output logic [3:0]              O_CPU_LEVEL,
  output logic                    O_NEST_BLOCK,
  output logic                    O_ALT_TABLE,
  output logic                    O_TRAP
);

  // ---------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------
  if (NUM_SRC < 30 || NUM_SRC > 32) begin : g_chk
    $error("NUM_SRC must lie in 30..32");
  end

  // ---------------------------------------------------------
  // declarations
  // ---------------------------------------------------------
  logic               awrdy_q;
  logic               aw_full_q;
  logic [7:0]         wa_q;
  logic               wrdy_q;
  logic               w_full_q;
  logic [15:0]        wd_q;
  logic [1:0]         ws_q;
  logic               bvalid_q;
  logic [1:0]         bresp_q;
  logic               arrdy_q;
  logic               rvalid_q;
  logic [31:0]        rdata_q;
  logic [1:0]         rresp_q;
  logic               wr_fire;
  logic [7:0]         ra;
  logic [15:0]        rd_val;
  logic               rd_ok;
  logic               wr_ok;
  logic [31:0]        flag_v;
  logic [31:0]        en_v;
  logic [2:0]         prio_v [32];
  logic [2:0]         lvl_q;
  logic               high_q;
  logic               nest_q;
  logic [2:0]         te_q;
  ipt_pkg::ipt_trap_t trap_q;
  ipt_pkg::ipt_trap_t trap_d;
  logic               alt_q;
  logic [2:0]         pol_q;
  logic [2:0]         s1_q;
  logic [2:0]         s2_q;
  logic [2:0]         s3_q;
  logic [2:0]         ext_edge;
  logic               best_found;
  logic [4:0]         best_idx;
  logic [2:0]         best_pri;
  logic [6:0]         best_vec;
  logic               irq_q;
  ipt_pkg::ipt_pend_t pend_q;
  logic               trap_out_q;

  // ---------------------------------------------------------
  // axi4-lite write channels
  // ---------------------------------------------------------
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

  // write address holding
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      awrdy_q   <= 1'b1;
      aw_full_q <= 1'b0;
      wa_q      <= 8'h00;
    end else if (I_AWVALID && awrdy_q) begin
      awrdy_q   <= 1'b0;
      aw_full_q <= 1'b1;
      wa_q      <= {I_AWADDR[7:2], 2'b00};
    end else if (wr_fire) begin
      awrdy_q   <= 1'b1;
      aw_full_q <= 1'b0;
    end
  end

  // write data holding, low half only
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      wrdy_q   <= 1'b1;
      w_full_q <= 1'b0;
      wd_q     <= 16'h0000;
      ws_q     <= 2'h0;
    end else if (I_WVALID && wrdy_q) begin
      wrdy_q   <= 1'b0;
      w_full_q <= 1'b1;
      wd_q     <= I_WDATA[15:0];
      ws_q     <= I_WSTRB[1:0];
    end else if (wr_fire) begin
      wrdy_q   <= 1'b1;
      w_full_q <= 1'b0;
    end
  end

  // thirty slots answer okay, the rest slave error
  assign wr_ok = (wa_q <= `IPT_OFF_LAST);

  // write response
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `IPT_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? `IPT_RESP_OKAY : `IPT_RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------
  // axi4-lite read channels
  // ---------------------------------------------------------
  assign ra = {I_ARADDR[7:2], 2'b00};

  // read mux over the register slots
  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = (ra <= `IPT_OFF_LAST);
    if (ra == `IPT_OFF_STATUS) begin
      rd_val[`IPT_SR_LVL_LO +: 3] = lvl_q;
    end else if (ra == `IPT_OFF_CORE) begin
      rd_val[`IPT_CORE_HIGH] = high_q;
    end else if (ra == `IPT_OFF_CTL1) begin
      rd_val[`IPT_C1_NEST]   = nest_q;
      rd_val[`IPT_C1_OVA]    = trap_q.ova;
      rd_val[`IPT_C1_OVB]    = trap_q.ovb;
      rd_val[`IPT_C1_COVA]   = trap_q.cova;
      rd_val[`IPT_C1_COVB]   = trap_q.covb;
      rd_val[`IPT_C1_ACC_A_OVERFLOW_TRAP_EN]  = te_q[2];
      rd_val[`IPT_C1_ACC_B_OVERFLOW_TRAP_EN]  = te_q[1];
      rd_val[`IPT_C1_CATASTROPHIC_TRAP_EN]  = te_q[0];
      rd_val[`IPT_C1_SFT]    = trap_q.sft;
      rd_val[`IPT_C1_DIV0]   = trap_q.div0;
      rd_val[`IPT_C1_DMA]    = trap_q.dma;
    end else if (ra == `IPT_OFF_CTL2) begin
      rd_val[`IPT_C2_ALT] = alt_q;
      rd_val[2:0]         = pol_q;
    end else if (ra == `IPT_OFF_FLAG0) begin
      rd_val = flag_v[15:0];
    end else if (ra == `IPT_OFF_FLAG0 + 8'h04) begin
      rd_val = flag_v[31:16];
    end else if (ra == `IPT_OFF_EN0) begin
      rd_val = en_v[15:0];
    end else if (ra == `IPT_OFF_EN0 + 8'h04) begin
      rd_val = en_v[31:16];
    end else if (ra == `IPT_OFF_PEND) begin
      rd_val = {1'b0, pend_q.vec, 4'h0, pend_q.lvl};
    end else if (ra >= `IPT_OFF_PRIO0 && ra < `IPT_OFF_PEND) begin
      for (int k = 0; k < 4; k++) begin
        rd_val[4*k +: 3] = prio_v[{ra[4:2], 2'(k)}];
      end
    end
  end

  // read answer one cycle after acceptance
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      arrdy_q  <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `IPT_RESP_OKAY;
    end else if (I_ARVALID && arrdy_q) begin
      arrdy_q  <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q  <= {16'h0000, rd_val};
      rresp_q  <= rd_ok ? `IPT_RESP_OKAY : `IPT_RESP_SLVERR;
    end else if (rvalid_q && I_RREADY) begin
      arrdy_q  <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------
  // external pin synchroniser and edge select
  // ---------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= I_EXT_PIN;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // polarity one falls, zero rises
  assign ext_edge = (pol_q & s3_q & ~s2_q) |
                    (~pol_q & s2_q & ~s3_q);

  // ---------------------------------------------------------
  // per-source flag, enable and priority
  // ---------------------------------------------------------
  for (genvar i = 0; i < 32; i++) begin : g_src
    localparam int R = i / 16;
    localparam int B = i % 16;
    localparam int P = (i % 4) * 4;
    if (i < NUM_SRC) begin : g_on
      logic       set;
      logic       fsel;
      logic       esel;
      logic       psel;
      logic       f_q;
      logic       e_q;
      logic [2:0] p_q;
      assign set = I_SRC_REQ[i] ||
                   (i == `IPT_EXT0_SRC && ext_edge[0]) ||
                   (i == `IPT_EXT1_SRC && ext_edge[1]) ||
                   (i == `IPT_EXT2_SRC && ext_edge[2]);
      assign fsel = wr_fire && ws_q[B/8] &&
                    wa_q == `IPT_OFF_FLAG0 + 8'(4*R);
      assign esel = wr_fire && ws_q[B/8] &&
                    wa_q == `IPT_OFF_EN0 + 8'(4*R);
      assign psel = wr_fire && ws_q[P/8] &&
                    wa_q == `IPT_OFF_PRIO0 + 8'(4*(i/4));
      // hardware set beats software write
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          f_q <= 1'b0;
        end else if (set) begin
          f_q <= 1'b1;
        end else if (fsel) begin
          f_q <= wd_q[B];
        end
      end
      // enable and priority fields
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          e_q <= 1'b0;
          p_q <= `IPT_PRIO_RST;
        end else begin
          if (esel) begin
            e_q <= wd_q[B];
          end
          if (psel) begin
            p_q <= wd_q[P +: 3];
          end
        end
      end
      assign flag_v[i] = f_q;
      assign en_v[i]   = e_q;
      assign prio_v[i] = p_q;
    end else begin : g_off
      assign flag_v[i] = 1'b0;
      assign en_v[i]   = 1'b0;
      assign prio_v[i] = 3'h0;
    end
  end

  // ---------------------------------------------------------
  // cpu priority level
  // ---------------------------------------------------------
  // core load first, software only when nesting allowed
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      lvl_q <= `IPT_LVL_RST;
    end else if (I_CPU_LEVEL_LOAD) begin
      lvl_q <= I_CPU_LEVEL_VAL[2:0];
    end else if (wr_fire && wa_q == `IPT_OFF_STATUS &&
                 ws_q[0] && !nest_q) begin
      lvl_q <= wd_q[`IPT_SR_LVL_LO +: 3];
    end
  end

  // high bit set by core only, software may clear
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      high_q <= 1'b0;
    end else if (I_CPU_LEVEL_LOAD) begin
      high_q <= I_CPU_LEVEL_VAL[3];
    end else if (I_TRAP_TAKEN) begin
      high_q <= 1'b1;
    end else if (wr_fire && wa_q == `IPT_OFF_CORE && ws_q[0] &&
                 !wd_q[`IPT_CORE_HIGH]) begin
      high_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------
  // control one: nesting block, trap enables and flags
  // ---------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      nest_q <= 1'b0;
      te_q   <= 3'h0;
    end else if (wr_fire && wa_q == `IPT_OFF_CTL1) begin
      if (ws_q[1]) begin
        nest_q <= wd_q[`IPT_C1_NEST];
        te_q   <= wd_q[`IPT_C1_ACC_A_OVERFLOW_TRAP_EN:`IPT_C1_CATASTROPHIC_TRAP_EN];
      end
    end
  end

  // sticky trap flags, event wins over write
  always_comb begin
    trap_d = trap_q;
    if (wr_fire && wa_q == `IPT_OFF_CTL1) begin
      if (ws_q[1]) begin
        trap_d.ova  = wd_q[`IPT_C1_OVA];
        trap_d.ovb  = wd_q[`IPT_C1_OVB];
        trap_d.cova = wd_q[`IPT_C1_COVA];
        trap_d.covb = wd_q[`IPT_C1_COVB];
      end
      if (ws_q[0]) begin
        trap_d.sft  = wd_q[`IPT_C1_SFT];
        trap_d.div0 = wd_q[`IPT_C1_DIV0];
        trap_d.dma  = wd_q[`IPT_C1_DMA];
      end
    end
    trap_d.ova  = trap_d.ova  | (I_TRAP_EVT.ova  & te_q[2]);
    trap_d.ovb  = trap_d.ovb  | (I_TRAP_EVT.ovb  & te_q[1]);
    trap_d.cova = trap_d.cova | (I_TRAP_EVT.cova & te_q[0]);
    trap_d.covb = trap_d.covb | (I_TRAP_EVT.covb & te_q[0]);
    trap_d.sft  = trap_d.sft  | I_TRAP_EVT.sft;
    trap_d.div0 = trap_d.div0 | I_TRAP_EVT.div0;
    trap_d.dma  = trap_d.dma  | I_TRAP_EVT.dma;
  end

  // trap flag state and summary output
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      trap_q     <= '0;
      trap_out_q <= 1'b0;
    end else begin
      trap_q     <= trap_d;
      trap_out_q <= |trap_d;
    end
  end

  // ---------------------------------------------------------
  // control two: table select and edge polarity
  // ---------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      alt_q <= 1'b0;
      pol_q <= 3'h0;
    end else if (wr_fire && wa_q == `IPT_OFF_CTL2) begin
      if (ws_q[1]) begin
        alt_q <= wd_q[`IPT_C2_ALT];
      end
      if (ws_q[0]) begin
        pol_q <= wd_q[2:0];
      end
    end
  end

  // ---------------------------------------------------------
  // arbitration and pending latch
  // ---------------------------------------------------------
  // highest priority wins, ties to lowest vector
  always_comb begin
    best_found = 1'b0;
    best_idx   = 5'h00;
    best_pri   = 3'h0;
    for (int i = 0; i < 32; i++) begin
      if (flag_v[i] && en_v[i] && !high_q &&
          prio_v[i] > lvl_q &&
          (!best_found || prio_v[i] > best_pri)) begin
        best_found = 1'b1;
        best_idx   = 5'(i);
        best_pri   = prio_v[i];
      end
    end
    best_vec = {2'b00, best_idx} + `IPT_VEC_FIRST;
  end

  // pending vector and level
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      irq_q  <= 1'b0;
      pend_q <= '0;
    end else begin
      irq_q <= best_found;
      if (best_found) begin
        pend_q.vec <= best_vec;
        pend_q.lvl <= {1'b0, best_pri};
      end
    end
  end

  // ---------------------------------------------------------
  // outputs
  // ---------------------------------------------------------
  assign O_AWREADY    = awrdy_q;
  assign O_WREADY     = wrdy_q;
  assign O_BVALID     = bvalid_q;
  assign O_BRESP      = bresp_q;
  assign O_ARREADY    = arrdy_q;
  assign O_RVALID     = rvalid_q;
  assign O_RDATA      = rdata_q;
  assign O_RRESP      = rresp_q;
  assign O_IRQ        = irq_q;
  assign O_PEND       = pend_q;
  assign O_CPU_LEVEL  = {high_q, lvl_q};
  assign O_NEST_BLOCK = nest_q;
  assign O_ALT_TABLE  = alt_q;
  assign O_TRAP       = trap_out_q;

  // ---------------------------------------------------------
  // assertions
  // ---------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  AST_EN_GATES: assert property (
    best_found |-> en_v[best_idx] && flag_v[best_idx])
    else $error("winner not enabled or not flagged");
  AST_ABOVE_LVL: assert property (
    best_found |-> prio_v[best_idx] > lvl_q && !high_q)
    else $error("winner not above cpu level");
  AST_USER_BLOCK: assert property (
    (high_q || lvl_q == 3'h7) |=> !irq_q)
    else $error("user interrupt at blocked level");
  AST_PEND_LATCH: assert property (
    best_found |=> irq_q && pend_q.vec == $past(best_vec) &&
                   pend_q.lvl == {1'b0, $past(best_pri)})
    else $error("pending vector not latched");
  AST_FLAG_SET: assert property (
    I_SRC_REQ[1] |=> flag_v[1])
    else $error("request flag not set");
  AST_FLAG_HOLD: assert property (
    flag_v[1] && !(wr_fire && wa_q == `IPT_OFF_FLAG0)
    |=> flag_v[1])
    else $error("flag dropped without write");
  AST_LVL_RO: assert property (
    nest_q && !I_CPU_LEVEL_LOAD |=> lvl_q == $past(lvl_q))
    else $error("level changed under nesting block");
  AST_HIGH_NOSET: assert property (
    !high_q && !I_TRAP_TAKEN && !I_CPU_LEVEL_LOAD |=> !high_q)
    else $error("high level bit set by software");
  AST_TRAP_STICKY: assert property (
    trap_q.div0 && !wr_fire |=> trap_q.div0)
    else $error("trap flag lost");
  AST_SET_WINS: assert property (
    I_TRAP_EVT.div0 |=> trap_q.div0)
    else $error("trap event lost to write");
  AST_OVA_GATE: assert property (
    !trap_q.ova && !te_q[2] && !wr_fire |=> !trap_q.ova)
    else $error("overflow flag set while trap disabled");
  AST_EXT_EDGE: assert property (
    ext_edge[0] |=> flag_v[`IPT_EXT0_SRC])
    else $error("external edge not flagged");
  AST_B_AFTER: assert property (
    wr_fire |=> bvalid_q)
    else $error("write response missing");

  COV_IRQ: cover property (best_found ##1 irq_q);
  COV_TRAP: cover property (I_TRAP_EVT.div0 ##1 O_TRAP);
  COV_NEG_EDGE: cover property (pol_q[0] && ext_edge[0]);
  COV_RD: cover property (I_ARVALID && arrdy_q ##1 rvalid_q);

endmodule

/* tb/ipt_far_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// sources, pins and core beside the block
// ----------------------------------------
module ipt_far_model #(
  parameter int NUM_SRC = 32
) (
  input  wire logic          i_clk,
  output logic [NUM_SRC-1:0] o_src_req,
  output logic [2:0]         o_ext_pin,
  output ipt_pkg::ipt_trap_t o_trap_evt,
  output logic               o_trap_taken,
  output logic               o_lvl_load,
  output logic [3:0]         o_lvl_val
);
  // everything idle from time zero
  initial begin
    o_src_req    = '0;
    o_ext_pin    = 3'h0;
    o_trap_evt   = '0;
    o_trap_taken = 1'b0;
    o_lvl_load   = 1'b0;
    o_lvl_val    = 4'h0;
  end
  // one cycle request from source n
  task automatic src(input int n);
    @(posedge i_clk);
    o_src_req <= NUM_SRC'(1) << n;
    @(posedge i_clk);
    o_src_req <= '0;
  endtask
  // one cycle trap events, ova first
  task automatic trap(input logic [6:0] m);
    @(posedge i_clk);
    o_trap_evt <= ipt_pkg::ipt_trap_t'(m);
    @(posedge i_clk);
    o_trap_evt <= '0;
  endtask
  // trap entry or full level load
  task automatic core(input logic tk, input logic [3:0] v);
    @(posedge i_clk);
    o_trap_taken <= tk;
    o_lvl_load   <= ~tk;
    o_lvl_val    <= v;
    @(posedge i_clk);
    o_trap_taken <= 1'b0;
    o_lvl_load   <= 1'b0;
  endtask
  // level on external pin zero
  task automatic pin0(input logic v);
    @(posedge i_clk);
    o_ext_pin[0] <= v;
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic               clk, rst_n, awv, wv, bry, arv, rry;
  logic               awr, wrd, bv, arr, rv, tk, ld;
  logic               irq, nest, alt, trap;
  logic [7:0]         awa, ara;
  logic [31:0]        wd, rdata, src;
  logic [3:0]         ws, lv, lvl;
  logic [1:0]         bresp, rresp, resp;
  logic [2:0]         pin;
  ipt_pkg::ipt_trap_t tev;
  ipt_pkg::ipt_pend_t pend;
  logic [15:0]        bitv [7] = '{16'h4000, 16'h2000, 16'h1000,
                                   16'h0800, 16'h0080, 16'h0040, 16'h0020};
  int                 n_fail = 0;
  int                 compares = 0;
  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ipt_top ipt_top_i (.I_CLK(clk), .I_RESET_N(rst_n), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrd),
    .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(bry),
    .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
    .O_RVALID(rv), .I_RREADY(rry), .O_RDATA(rdata), .O_RRESP(rresp),
    .I_SRC_REQ(src), .I_EXT_PIN(pin), .I_TRAP_EVT(tev),
    .I_TRAP_TAKEN(tk), .I_CPU_LEVEL_LOAD(ld), .I_CPU_LEVEL_VAL(lv),
    .O_IRQ(irq), .O_PEND(pend), .O_CPU_LEVEL(lvl), .O_NEST_BLOCK(nest),
    .O_ALT_TABLE(alt), .O_TRAP(trap));
  ipt_far_model ipt_far_model_i (.i_clk(clk), .o_src_req(src),
    .o_ext_pin(pin), .o_trap_evt(tev), .o_trap_taken(tk),
    .o_lvl_load(ld), .o_lvl_val(lv));
  // -----------------
  // shared tasks
  // -----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bounded wait ran out
  task automatic tmo(input int n);
    if (n >= 40) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk);
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= a;
    wd  <= {16'h0000, d};
    bry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    bry  <= 1'b0;
    resp = bresp;
    tmo(n);
  endtask
  // bus read compared with exp
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int n;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rry  <= 1'b0;
    resp = rresp;
    tmo(n);
    chk(rdata, exp);
  endtask
  // -----------------
  // scenarios
  // -----------------
  task automatic t_reset();
    chk(pend, 32'h0);
    chk({nest, alt, trap, irq, lvl}, 32'h0);
    rd(8'h20, 32'h4444);
    rd(8'h74, 32'h0);
    chk(resp, 32'h0);
    rd(8'h78, 32'h0);
    chk(resp, 32'h2);
    wr(8'h78, 16'hFFFF);
    chk(resp, 32'h2);
    wr(8'h74, 16'hFFFF);
    chk(resp, 32'h0);
  endtask
  task automatic t_flag();
    wr(8'h20, 16'h0005);
    ipt_far_model_i.src(0);
    ipt_far_model_i.src(1);
    cyc(2);
    chk(irq, 32'h0);
    rd(8'h10, 32'h3);
    wr(8'h18, 16'h0001);
    cyc(2);
    chk(irq, 32'h1);
    rd(8'h40, 32'h0805);
    chk(pend, 32'h085);
    wr(8'h00, 16'h00A0);
    cyc(2);
    chk({lvl, irq}, 32'hA);
    wr(8'h00, 16'h0080);
    cyc(2);
    chk(irq, 32'h1);
    wr(8'h20, 16'h0007);
    wr(8'h00, 16'h00E0);
    cyc(2);
    chk(irq, 32'h0);
    rd(8'h00, 32'hE0);
  endtask
  task automatic t_high();
    wr(8'h04, 16'h0008);
    cyc(2);
    chk(lvl, 32'h7);
    ipt_far_model_i.core(1'b1, 4'h0);
    cyc(2);
    chk(lvl, 32'hF);
    rd(8'h04, 32'h8);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h00C0);
    cyc(2);
    chk(irq, 32'h1);
    ipt_far_model_i.core(1'b0, 4'h9);
    cyc(2);
    chk({lvl, irq}, 32'h12);
  endtask
  task automatic t_nest();
    wr(8'h08, 16'h8000);
    wr(8'h00, 16'h0060);
    cyc(2);
    chk({nest, lvl}, 32'h19);
    wr(8'h08, 16'h0000);
    wr(8'h00, 16'h0060);
    cyc(2);
    chk({nest, lvl}, 32'hB);
    wr(8'h04, 16'h0000);
    wr(8'h10, 16'h0000);
    rd(8'h10, 32'h0);
  endtask
  task automatic t_trap();
    ipt_far_model_i.trap(7'h78);
    rd(8'h08, 32'h0);
    wr(8'h08, 16'h0700);
    for (int k = 0; k < 7; k++) begin
      ipt_far_model_i.trap(7'h40 >> k);
      rd(8'h08, {16'h0000, bitv[k] | 16'h0700});
      chk(trap, 32'h1);
      wr(8'h08, 16'h0700);
      chk(trap, 32'h0);
    end
  endtask
  task automatic t_ctl2();
    wr(8'h0C, 16'h8000);
    cyc(1);
    chk(alt, 32'h1);
    ipt_far_model_i.pin0(1'b1);
    cyc(6);
    rd(8'h10, 32'h1);
    wr(8'h0C, 16'h8001);
    wr(8'h10, 16'h0000);
    ipt_far_model_i.pin0(1'b0);
    cyc(6);
    rd(8'h10, 32'h1);
    rd(8'h0C, 32'h8001);
    ws <= 4'h2;
    wr(8'h0C, 16'h0007);
    ws <= 4'hF;
    rd(8'h0C, 32'h1);
  endtask
  // reset in mid-run returns every state to its reset value
  task automatic t_rst2();
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    chk({nest, alt, trap, irq, lvl}, 32'h0);
    chk(pend, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h0C, 32'h0);
    rd(8'h20, 32'h4444);
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    awv   = 1'b0;
    wv    = 1'b0;
    bry   = 1'b0;
    arv   = 1'b0;
    rry   = 1'b0;
    awa   = 8'h00;
    ara   = 8'h00;
    wd    = 32'h0;
    ws    = 4'hF;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flag();
    t_high();
    t_nest();
    t_trap();
    t_ctl2();
    t_rst2();
    wrap_up();
  end
endmodule
